// ==== src/mmbc_pkg.sv ====
// package for the minimum-mode bus control block
// assumes a single 50 MHz clock and an active-high asynchronous reset
//
// Behaviour
// R1 - queue status shown cycle after operation
// R2 - status codes: none, first, flush, subsequent
// R3 - strap high selects minimum-mode pin functions
// R4 - memory/io select valid T4 to T4; code drives it from T1 to T4
// R5 - control outputs float during hold acknowledge; code keeps int_ack_strobe_n driven
// R6 - write strobe low in T2, T3, waits
// R7 - interrupt strobe low in T2, T3, waits
// R8 - latch strobe high during every T1
// R9 - latch strobe never floated
// R10 - direction high transmit, same window as select
// R11 - transceiver enable on every access cycle
// R12 - enable mid-T2 read, start-T2 write, to mid-T4
// R13 - requester holds request high while needed
// R14 - acknowledge mid T4 or idle, float bus
// R15 - drop acknowledge after request low, drive later
// R16 - release only when cycle conditions allow
// R17 - requester synchronises hold request input
// R18 - cycle runs T1, T2, T3, waits, T4
package mmbc_pkg;

  // queue status codes
  localparam logic [1:0] MMBC_QS_NONE  = 2'h0;
  localparam logic [1:0] MMBC_QS_FIRST = 2'h1;
  localparam logic [1:0] MMBC_QS_FLUSH = 2'h2;
  localparam logic [1:0] MMBC_QS_SUBSQ = 2'h3;

  // bus cycle kinds
  typedef enum logic [1:0] {
    MMBC_CYC_READ,
    MMBC_CYC_WRITE,
    MMBC_CYC_INT_ACK_STROBE_N
  } mmbc_cyc_t;

  // bus timing states
  typedef enum logic [2:0] {
    MMBC_ST_IDLE,
    MMBC_ST_T1,
    MMBC_ST_T2,
    MMBC_ST_T3,
    MMBC_ST_WAIT,
    MMBC_ST_T4,
    MMBC_ST_HOLD
  } mmbc_state_t;

  // reset values
  localparam logic [1:0] MMBC_QS_RESET = 2'h0;

endpackage : mmbc_pkg

// ==== src/mmbc_sync.sv ====
// two-flop synchroniser for one pin input
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module mmbc_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // pin and result
  input  wire logic pin_in,
  output var  logic level_out
);
  logic stage1_reg;  // read only by the second stage

  // two stages, no logic between
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1_reg <= 1'b0;
      level_out  <= 1'b0;
    end else begin
      stage1_reg <= pin_in;
      level_out  <= stage1_reg;
    end
  end
endmodule : mmbc_sync
`default_nettype wire

// ==== src/mmbc_qstat.sv ====
// queue status output stage
// assumes queue events arrive from same-clock logic, one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module mmbc_qstat
  import mmbc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // queue events this cycle
  input  wire logic       q_first,
  input  wire logic       q_flush,
  input  wire logic       q_subsq,
  // status pins
  output var  logic [1:0] queue_status
);
  // R1 registered so it shows in the following cycle
  // R2 flush wins if events collide
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      queue_status <= MMBC_QS_RESET;
    end else if (q_flush) begin
      queue_status <= MMBC_QS_FLUSH;
    end else if (q_first) begin
      queue_status <= MMBC_QS_FIRST;
    end else if (q_subsq) begin
      queue_status <= MMBC_QS_SUBSQ;
    end else begin
      queue_status <= MMBC_QS_NONE;
    end
  end
endmodule : mmbc_qstat
`default_nettype wire

// ==== src/mmbc_top.sv ====
// minimum-mode local bus control strobes and hold handshake
// assumes internal requests are same-clock; hold_req and ready pins are not
// half-cycle edges are modelled with negedge flops of the same clock
`timescale 1ns/1ps
`default_nettype none
module mmbc_top
  import mmbc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // configuration strap, pin
  input  wire logic       config_strap,
  // internal bus request
  input  wire logic       cyc_req,
  input  wire logic [1:0] cyc_kind,
  input  wire logic       cyc_mem,
  input  wire logic       cyc_odd_low,
  input  wire logic       cyc_first_int_ack_strobe_n,
  input  wire logic       lock_active,
  output logic            cyc_start,
  output logic            cyc_done,
  // memory ready pin
  input  wire logic       ready,
  // internal queue events
  input  wire logic       q_first,
  input  wire logic       q_flush,
  input  wire logic       q_subsq,
  // hold handshake pins
  input  wire logic       hold_req,
  output var  logic       bus_yield_ack,
  // control pins
  output var  logic       mem_io_sel,
  output logic            mem_io_sel_oe,
  output var  logic       write_strobe_n,
  output logic            write_strobe_n_oe,
  output logic            int_ack_strobe_n,
  output logic            int_ack_strobe_n_oe,
  output var  logic       addr_latch,
  output var  logic       transceiver_direction,
  output logic            transceiver_direction_oe,
  output logic            transceiver_enable_n,
  output logic            transceiver_enable_n_oe,
  // queue status pins
  output var  logic [1:0] queue_status,
  output logic            queue_status_oe
);
  mmbc_state_t state_reg;       // bus timing state
  mmbc_cyc_t   kind_reg;        // kind of current cycle
  logic        strap_sync;      // synchronised strap
  logic        min_mode_reg;    // strap sampled every clock after reset
  logic        hold_sync;       // synchronised hold request
  logic        ready_sync;      // synchronised ready
  logic        hold_seen_reg;   // request seen by T2
  logic        no_release_reg;  // cycle must not be split
  logic        mio_drive_reg;   // select/direction window
  logic        den_mid_reg;     // enable from mid T2
  logic        den_end_reg;     // enable stops mid T4
  logic        bus_yield_ack_mid_reg;    // hold ack raised mid cycle
  logic        release_ok;      // hold may be taken now
  logic        floated;         // bus given away

  // strap and pin synchronisers
  mmbc_sync u_strap (.clk(clk), .reset(reset), .pin_in(config_strap), .level_out(strap_sync));
  mmbc_sync u_hold  (.clk(clk), .reset(reset), .pin_in(hold_req),     .level_out(hold_sync));
  mmbc_sync u_ready (.clk(clk), .reset(reset), .pin_in(ready),        .level_out(ready_sync));

  // queue status stage
  mmbc_qstat u_qstat (
    .clk          (clk),
    .reset        (reset),
    .q_first      (q_first),
    .q_flush      (q_flush),
    .q_subsq      (q_subsq),
    .queue_status (queue_status)
  );

  // strap followed every clock after reset, cleared under it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      min_mode_reg <= 1'b0;
    end else begin
      min_mode_reg <= strap_sync;
    end
  end

  // R16 release allowed only when cycle is splittable
  assign release_ok = hold_sync && (!cyc_mem_active() || (hold_seen_reg && !no_release_reg));

  function automatic logic cyc_mem_active();
    cyc_mem_active = (state_reg != MMBC_ST_IDLE) && (state_reg != MMBC_ST_HOLD);
  endfunction : cyc_mem_active

  // R18 bus state sequence
  // R15 hold left once request seen low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= MMBC_ST_IDLE;
    end else begin
      unique case (state_reg)
        MMBC_ST_IDLE: begin
          if (hold_sync) begin
            state_reg <= MMBC_ST_HOLD;
          end else if (cyc_req) begin
            state_reg <= MMBC_ST_T1;
          end
        end
        MMBC_ST_T1: state_reg <= MMBC_ST_T2;
        MMBC_ST_T2: state_reg <= MMBC_ST_T3;
        MMBC_ST_T3: begin
          // wait states while memory not ready
          state_reg <= ready_sync ? MMBC_ST_T4 : MMBC_ST_WAIT;
        end
        MMBC_ST_WAIT: state_reg <= ready_sync ? MMBC_ST_T4 : MMBC_ST_WAIT;
        MMBC_ST_T4: begin
          if (release_ok) begin
            state_reg <= MMBC_ST_HOLD;
          end else if (cyc_req && !hold_sync) begin
            state_reg <= MMBC_ST_T1;
          end else if (hold_sync) begin
            // locked or split cycle: keep bus if a next cycle is requested, else idle
            state_reg <= cyc_req ? MMBC_ST_T1 : MMBC_ST_IDLE;
          end else begin
            state_reg <= MMBC_ST_IDLE;
          end
        end
        MMBC_ST_HOLD: begin
          if (!hold_sync) begin
            state_reg <= MMBC_ST_IDLE;
          end
        end
      endcase
    end
  end

  // cycle attributes captured at start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      kind_reg       <= MMBC_CYC_READ;
      no_release_reg <= 1'b0;
    end else if (cyc_start) begin
      kind_reg       <= mmbc_cyc_t'(cyc_kind);
      no_release_reg <= !cyc_mem || cyc_odd_low || cyc_first_int_ack_strobe_n || lock_active;
    end
  end

  // R16 request must arrive by T2
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_seen_reg <= 1'b0;
    end else if (state_reg == MMBC_ST_T1 || state_reg == MMBC_ST_T2) begin
      hold_seen_reg <= hold_seen_reg || hold_sync;
    end else if (state_reg == MMBC_ST_T4 || state_reg == MMBC_ST_IDLE) begin
      hold_seen_reg <= 1'b0;
    end
  end

  assign cyc_start = (state_reg == MMBC_ST_IDLE && cyc_req && !hold_sync) ||
                     (state_reg == MMBC_ST_T4 && cyc_req && !release_ok);
  assign cyc_done  = (state_reg == MMBC_ST_T4);

  // R4 select valid from T1 through final T4
  // R10 direction shares the same window
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mio_drive_reg         <= 1'b0;
      mem_io_sel            <= 1'b0;
      transceiver_direction <= 1'b0;
    end else if (cyc_start) begin
      mio_drive_reg         <= 1'b1;
      mem_io_sel            <= cyc_mem;
      transceiver_direction <= (mmbc_cyc_t'(cyc_kind) == MMBC_CYC_WRITE);
    end else if (state_reg == MMBC_ST_T4 || state_reg == MMBC_ST_HOLD) begin
      mio_drive_reg         <= 1'b0;
    end
  end

  // R6 write strobe over T2, T3 and waits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      write_strobe_n <= 1'b1;
    end else begin
      write_strobe_n <= !(kind_reg == MMBC_CYC_WRITE &&
                          (state_reg == MMBC_ST_T1 || state_reg == MMBC_ST_T2 ||
                           (state_reg == MMBC_ST_T3 && !ready_sync) ||
                           (state_reg == MMBC_ST_WAIT && !ready_sync)));
    end
  end

  // R12 read and acknowledge enable starts mid T2, all end mid T4
  always_ff @(negedge clk or posedge reset) begin
    if (reset) begin
      den_mid_reg <= 1'b0;
      den_end_reg <= 1'b0;
    end else begin
      den_mid_reg <= (state_reg == MMBC_ST_T2 || state_reg == MMBC_ST_T3 ||
                      state_reg == MMBC_ST_WAIT);
      den_end_reg <= (state_reg == MMBC_ST_T4);
    end
  end

  // R14 acknowledge rises mid T4 or idle
  always_ff @(negedge clk or posedge reset) begin
    if (reset) begin
      bus_yield_ack_mid_reg <= 1'b0;
    end else begin
      bus_yield_ack_mid_reg <= ((state_reg == MMBC_ST_T4 || state_reg == MMBC_ST_IDLE) && release_ok) ||
                      (state_reg == MMBC_ST_HOLD && hold_sync);
    end
  end

  // R14 acknowledge pin rises mid T4 or idle, with the float
  // R15 drops mid cycle once request seen low
  always_ff @(negedge clk or posedge reset) begin
    if (reset) begin
      bus_yield_ack <= 1'b0;
    end else begin
      bus_yield_ack <= ((state_reg == MMBC_ST_T4 || state_reg == MMBC_ST_IDLE) && release_ok) ||
                       (state_reg == MMBC_ST_HOLD && hold_sync);
    end
  end

  // R8 latch strobe high during T1
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      addr_latch <= 1'b0;
    end else begin
      addr_latch <= cyc_start;
    end
  end

  // R7 acknowledge strobe follows write-strobe window on int_ack_strobe_n
  assign int_ack_strobe_n = !(kind_reg == MMBC_CYC_INT_ACK_STROBE_N &&
                              (state_reg == MMBC_ST_T2 || state_reg == MMBC_ST_T3 ||
                               state_reg == MMBC_ST_WAIT));

  // R11 enable during every access kind
  // R12 write from start T2, others from mid T2
  assign transceiver_enable_n = !(((kind_reg == MMBC_CYC_WRITE) &&
                                   (state_reg == MMBC_ST_T2 || state_reg == MMBC_ST_T3 ||
                                    state_reg == MMBC_ST_WAIT)) ||
                                  ((kind_reg != MMBC_CYC_WRITE) && den_mid_reg &&
                                   state_reg != MMBC_ST_T4) ||
                                  (state_reg == MMBC_ST_T4 && !den_end_reg));

  // R5 float while acknowledge is up
  // R14 float at the moment acknowledge rises
  assign floated = bus_yield_ack_mid_reg || bus_yield_ack;

  // R3 only minimum mode drives these pins
  assign mem_io_sel_oe            = min_mode_reg && !floated && mio_drive_reg;
  assign write_strobe_n_oe        = min_mode_reg && !floated;
  assign transceiver_direction_oe = min_mode_reg && !floated && mio_drive_reg;
  assign transceiver_enable_n_oe  = min_mode_reg && !floated;
  assign int_ack_strobe_n_oe      = min_mode_reg;
  // queue status owns the shared pins in the other mode
  assign queue_status_oe          = !min_mode_reg;
  // R9 latch strobe has no enable, always driven

endmodule : mmbc_top
`default_nettype wire

// ==== verification/mmbc_monitor.sv ====
// checker for the minimum-mode bus control block ports
// assumes it is bound onto mmbc_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module mmbc_monitor
  import mmbc_pkg::*;
(
  // clock and reset
  input wire logic       clk, reset,
  // internal side
  input wire logic       cyc_start, cyc_done, cyc_mem, q_first, q_flush, q_subsq,
  input wire logic [1:0] cyc_kind, queue_status,
  // pins
  input wire logic       hold_req, bus_yield_ack, addr_latch, queue_status_oe,
  input wire logic       mem_io_sel, mem_io_sel_oe, write_strobe_n, write_strobe_n_oe, int_ack_strobe_n,
  input wire logic       transceiver_direction, transceiver_direction_oe, transceiver_enable_n,
  input wire logic       transceiver_enable_n_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // one latch pulse, then low again in T2
  sequence s_t1;
    ##1 addr_latch ##1 !addr_latch;
  endsequence
  property p_latch; cyc_start |-> s_t1; endproperty
  a_latch: assert property (p_latch)
    else $error("latch pulse wrong");
  // T1 T2 T3 never done; waits bounded by the slow model
  sequence s_body;
    !cyc_done [*3] ##[0:40] cyc_done;
  endsequence
  property p_len; addr_latch |-> s_body; endproperty
  a_len: assert property (p_len)
    else $error("cycle length wrong");
  property p_sel;
    cyc_start |=> mem_io_sel == $past(cyc_mem) && transceiver_direction == ($past(cyc_kind) == 2'h1);
  endproperty
  a_sel: assert property (p_sel)
    else $error("select or direction wrong");
  property p_int_ack_strobe_n; cyc_start |=> ##1 (int_ack_strobe_n == ($past(cyc_kind, 2) != 2'h2)); endproperty
  a_int_ack_strobe_n: assert property (p_int_ack_strobe_n)
    else $error("interrupt strobe wrong");
  property p_wr; cyc_start && cyc_kind == 2'h1 |=> ##2 !write_strobe_n; endproperty
  a_wr: assert property (p_wr)
    else $error("write strobe missing");
  // mid-T2: write already enabled, read and int_ack_strobe_n not yet
  property p_en; @(negedge clk) $rose(addr_latch) |=> transceiver_enable_n == !transceiver_direction; endproperty
  a_en: assert property (p_en)
    else $error("enable window wrong");
  property p_float;
    bus_yield_ack |-> !(mem_io_sel_oe | write_strobe_n_oe | transceiver_direction_oe | transceiver_enable_n_oe);
  endproperty
  a_float: assert property (p_float)
    else $error("pins driven in hold");
  property p_ack_cause; $rose(bus_yield_ack) |-> $past(hold_req, 2); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_ack_drop; $fell(hold_req) |-> ##[1:5] !bus_yield_ack; endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("ack not dropped");
  property p_qs; q_flush |=> queue_status == MMBC_QS_FLUSH; endproperty
  a_qs: assert property (p_qs)
    else $error("flush status wrong");
  property p_drive; addr_latch && !queue_status_oe |-> mem_io_sel_oe && transceiver_enable_n_oe; endproperty
  a_drive: assert property (p_drive)
    else $error("minimum mode pins idle");
endmodule : mmbc_monitor
bind mmbc_top mmbc_monitor u_mon (.*);
`default_nettype wire

// ==== verification/mmbc_partner.sv ====
// far side model: slow memory and a second bus master
// assumes the bench sets want and waits at rising edges
`timescale 1ns/1ps
`default_nettype none
module mmbc_partner (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // bench controls
  input  wire logic       want,
  input  wire logic [3:0] waits,
  // bus side
  input  wire logic       addr_latch,
  output wire logic       ready,
  output var  logic       hold_req
);
  logic [3:0] cnt_reg; // wait cycles still owed

  always_ff @(posedge clk or posedge reset) begin
    if (reset) hold_req <= 1'h0;
    else hold_req <= want;
  end
  // slow memory stalls after each latch pulse
  always_ff @(posedge clk or posedge reset) begin
    if (reset) cnt_reg <= 4'h0;
    else if (addr_latch) cnt_reg <= waits;
    else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
  end
  // not ready from the latch pulse on, so the slow sync still sees it by T3
  assign ready = (cnt_reg == 4'h0) && !(addr_latch && waits != 4'h0);
endmodule : mmbc_partner
`default_nettype wire

// ==== verification/tb_min_mode_bus_control.sv ====
// self-checking bench for the bus control block
// assumes mmbc_monitor is bound and mmbc_partner is the far side
`timescale 1ns/1ps
`default_nettype none
module tb_min_mode_bus_control import mmbc_pkg::*;;
  logic       clk, reset, config_strap, cyc_req, cyc_mem, cyc_odd_low, cyc_first_int_ack_strobe_n, lock_active;
  logic       q_first, q_flush, q_subsq, want, ready, hold_req, cyc_start, cyc_done, bus_yield_ack;
  logic       mem_io_sel, mem_io_sel_oe, write_strobe_n, write_strobe_n_oe, int_ack_strobe_n;
  logic       int_ack_strobe_n_oe, addr_latch, transceiver_direction, transceiver_direction_oe;
  logic       transceiver_enable_n, transceiver_enable_n_oe, queue_status_oe;
  logic [1:0] cyc_kind, queue_status;
  logic [3:0] waits;
  int         err_total, cmp_count;

  mmbc_top dut (.*);
  mmbc_partner u_far (.*);

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic cmpv(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpv
  task automatic cmpn(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      err_total++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : cmpn
  task automatic test_done;
    $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  function automatic logic probe(input int s);
    case (s)
      0: return cyc_start === 1'h1;
      1: return cyc_done === 1'h1;
      2: return bus_yield_ack === 1'h1;
      default: return bus_yield_ack === 1'h0;
    endcase
  endfunction : probe
  // bounded wait, checked before each step so nothing is missed
  task automatic wait_on(input int s, output int n);
    n = 0;
    while (!probe(s) && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 60) begin
      cmpn(n, 0);
      test_done;
    end
  endtask : wait_on
  // one cycle; counts T2..T4 samples of the write, interrupt and enable strobes
  task automatic run(input logic [1:0] k, input logic m, output int len, wl, il, el);
    @(posedge clk);
    cyc_req <= 1'h1;
    cyc_kind <= k;
    cyc_mem <= m;
    #1;
    wait_on(0, len);
    @(posedge clk);
    cyc_req <= 1'h0;
    #1;
    cmpv(addr_latch, 1);
    cmpv({mem_io_sel, transceiver_direction}, {m, k == 2'h1});
    cmpv(mem_io_sel_oe & transceiver_enable_n_oe, 1);
    {len, wl, il, el} = '0;
    while (!cyc_done && len < 60) begin
      @(posedge clk);
      #1;
      len++;
      wl += (write_strobe_n === 1'h0);
      il += (int_ack_strobe_n === 1'h0);
      el += (transceiver_enable_n === 1'h0);
    end
  endtask : run
  // every kind, memory and io, no waits
  task automatic t_kinds;
    int len, wl, il, el;
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 2; m++) begin
        run(k[1:0], m[0], len, wl, il, el);
        cmpn(len, 3);
        cmpn(wl, k == 1 ? 2 : 0);
        cmpn(il, k == 2 ? 2 : 0);
        cmpn(el, k == 1 ? 3 : 2);
      end
    end
  endtask : t_kinds
  // slow memory stretches a write
  task automatic t_wait;
    int len, wl, il, el;
    @(posedge clk);
    waits <= 4'h6;
    run(2'h1, 1'h0, len, wl, il, el);
    cmpn(len > 3, 1);
    cmpn(wl > 1, 1);
    waits <= 4'h0;
  endtask : t_wait
  // all event mixes; flush wins, then first
  task automatic t_queue;
    logic [1:0] exp;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {q_flush, q_first, q_subsq} <= i[2:0];
      exp = i[2] ? MMBC_QS_FLUSH : i[1] ? MMBC_QS_FIRST : i[0] ? MMBC_QS_SUBSQ : MMBC_QS_NONE;
      @(posedge clk);
      {q_flush, q_first, q_subsq} <= 3'h0;
      #1;
      cmpv(queue_status, exp);
    end
  endtask : t_queue
  // hold from idle, cycle refused, then resumed
  task automatic t_hold;
    int n;
    @(posedge clk);
    want <= 1'h1;
    #1;
    wait_on(2, n);
    cmpv({mem_io_sel_oe, write_strobe_n_oe, transceiver_direction_oe, transceiver_enable_n_oe}, 0);
    cmpv(addr_latch, 0);
    @(posedge clk);
    cyc_req <= 1'h1;
    repeat (5) begin
      @(posedge clk);
      #1;
      cmpv(cyc_start | addr_latch, 0);
    end
    @(posedge clk);
    want <= 1'h0;
    #1;
    wait_on(3, n);
    cmpn(n < 6, 1);
    wait_on(0, n);
    @(posedge clk);
    cyc_req <= 1'h0;
    #1;
    cmpv({addr_latch, mem_io_sel_oe}, 3);
  endtask : t_hold
  // hold during a memory read; a blocking flag keeps the bus
  task automatic t_release(input logic [2:0] f);
    int n;
    @(posedge clk);
    want <= 1'h1;
    {lock_active, cyc_first_int_ack_strobe_n, cyc_odd_low} <= f;
    cyc_kind <= 2'h0;
    cyc_mem <= 1'h1;
    @(posedge clk);
    cyc_req <= 1'h1;
    #1;
    wait_on(0, n);
    @(posedge clk);
    #1;
    wait_on(1, n);
    @(posedge clk);
    cyc_req <= 1'h0;
    #1;
    cmpv({bus_yield_ack, addr_latch}, {f == 3'h0, f != 3'h0});
    wait_on(2, n);
    @(posedge clk);
    want <= 1'h0;
    {lock_active, cyc_first_int_ack_strobe_n, cyc_odd_low} <= 3'h0;
    #1;
    wait_on(3, n);
  endtask : t_release
  // strap low hands the shared pins back
  task automatic t_strap;
    @(posedge clk);
    config_strap <= 1'h0;
    repeat (6) @(posedge clk);
    #1;
    cmpv(queue_status_oe, 1);
    @(posedge clk);
    config_strap <= 1'h1;
    repeat (6) @(posedge clk);
    #1;
    cmpv(queue_status_oe, 0);
  endtask : t_strap

  initial begin
    {reset, config_strap} = 2'h3;
    {cyc_req, cyc_mem, cyc_odd_low, cyc_first_int_ack_strobe_n, lock_active, want} = 6'h00;
    {q_first, q_flush, q_subsq, cyc_kind, waits} = 9'h000;
    {err_total, cmp_count} = '0;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    repeat (4) @(posedge clk);
    t_kinds;
    t_wait;
    t_queue;
    t_hold;
    for (int i = 0; i < 4; i++) t_release(i == 0 ? 3'h0 : 3'h1 << (i - 1));
    t_strap;
    test_done;
  end
endmodule : tb_min_mode_bus_control
`default_nettype wire
